// ===== rtl/irc_consts.svh
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH
// Register byte offsets
`define IRC_A_IFMODE    12'h000
`define IRC_A_NETCFG    12'h004
`define IRC_A_NETIP     12'h008
`define IRC_A_NETMASK   12'h00C
`define IRC_A_NETGW     12'h010
`define IRC_A_NETDNS1   12'h014
`define IRC_A_NETDNS2   12'h018
`define IRC_A_NETSTRLEN 12'h01C
`define IRC_A_NETSTAT   12'h020
`define IRC_A_NSTIP     12'h024
`define IRC_A_NSTDNS2   12'h034
`define IRC_A_OPCOND    12'h040
`define IRC_A_OPMASK    12'h044
`define IRC_A_OPEVENT   12'h048
`define IRC_A_RDGFLAG   12'h060
`define IRC_A_RELAY1    12'h070
`define IRC_A_RELAY2    12'h074
`define IRC_A_RELAY_STATE_QUERY   12'h078
`define IRC_A_OUTBASE   12'h080
`define IRC_A_CURVE     12'h100
`define IRC_A_CRVPT1    12'h104
`define IRC_A_CRVPT6    12'h118
// Per-output sub-register index (output block stride 0x20)
`define IRC_S_MODE      3'h0
`define IRC_S_MOUT      3'h1
`define IRC_S_SETPOINT_CMD      3'h2
`define IRC_S_PGAIN     3'h3
`define IRC_S_IGAIN     3'h4
`define IRC_S_DGAIN     3'h5
`define IRC_S_RAMP      3'h6
`define IRC_S_WORKSP    3'h7
// Field limits
`define IRC_IFMODE_MAX  2'h2
`define IRC_INPUT_MAX   3'h4
`define IRC_MOUT_MAX    16'h2710
`define IRC_RATE_MAX    10'h3E8
`define IRC_HOST_MAX    4'hF
`define IRC_DOMAIN_MAX  7'h40
`define IRC_DESC_MAX    6'h20
`define IRC_SN_MAX      4'hA
`define IRC_DEST_MIN    8'h15
`define IRC_DEST_MAX    8'h3B
// Reset values
`define IRC_RST_WORD    32'h0000_0000
`define IRC_RST_MASK    8'h00
// Timing
`define IRC_CLK_HZ      64'd50000000
`define IRC_RAMP_TICK_MS 64'd60
`define IRC_RAMP_TICK_CYC ((`IRC_RAMP_TICK_MS * `IRC_CLK_HZ) / 64'd1000)
`endif

// ===== rtl/irc_pkg.sv
package irc_pkg;
  typedef enum logic [2:0] {
    IRC_OM_OFF, IRC_OM_PID, IRC_OM_ZONE, IRC_OM_OPEN, IRC_OM_MONITOR, IRC_OM_WARMUP
  } irc_out_mode_type;
  typedef enum logic [1:0] {
    IRC_IF_LOCAL, IRC_IF_REMOTE, IRC_IF_LOCKOUT
  } irc_if_mode_type;
  typedef enum logic [1:0] {
    IRC_RL_OFF, IRC_RL_ON, IRC_RL_ALARM
  } irc_relay_mode_type;
  typedef enum logic [1:0] {
    IRC_AL_LOW, IRC_AL_HIGH, IRC_AL_BOTH
  } irc_alarm_type;
endpackage

// ===== rtl/irc_unit.sv
`timescale 1ns/100ps
`include "irc_consts.svh"
// How it works
// R1 - Interface mode accepts 0 local, 1 remote, 2 lockout; reads back.
// R2 - Manual output per output, effective only in PID, zone or open loop.
// R3 - Network flags, five addresses and string lengths capped 15, 64, 32.
// R4 - Network status reports link code 0 to 9.
// R5 - Unconfigured network reports zero addresses on the status view.
// R6 - Enable mask gates event bits onto the summary; condition, mask readable.
// R7 - Event bits latch on condition and clear when read, except bits whose condition is present in the read cycle.
// R8 - Each output holds a control mode code 0 to 5.
// R9 - Each output holds control input 0 none, 1 to 4 inputs A to D.
// R10 - Each output holds a power-up enable flag.
// R11 - Modes 1,2 only on outputs 1,2; modes 4,5 only on outputs 3,4.
// R12 - P, I, D stored per output and only read back.
// R13 - Ramp on/off and rate 0.1 to 100 K/min; zero rate means off.
// R14 - Working setpoint moves toward target at stored rate, up or down.
// R15 - Ramp status is 1 while working setpoint still moves, else 0.
// R16 - Range 0 to 3 on outputs 1,2; 0 or 1 on outputs 3,4.
// R17 - Range ignored in off mode; monitor mode always on.
// R18 - Reading flags per input at bits 0, 4, 5, 6, 7; zero means valid.
// R19 - Relay in alarm mode follows chosen input alarm: low, high or either.
// R20 - Relay state reads 0 off, 1 on for relay 1 or 2.
// R21 - Setpoint per output; outputs 3,4 honour it only in warmup mode.
// R22 - Curve generation: standard 1, 6 or 7, user curve 21-59, serial 10 max.
// R23 - Every writable register reads back its last accepted values in command order; status views show live state.
module irc_unit import irc_pkg::*; #(
  parameter int unsigned RAMP_TICK_CYC = 32'(`IRC_RAMP_TICK_CYC)
) (
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RESET_N,
  // APB slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [11:0]   PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // Status pins from the instrument
  input  wire logic [3:0]    LINK_STATE,
  input  wire logic          NET_UNCONF,
  input  wire logic [7:0]    OP_COND,
  input  wire logic [19:0]   RDG_FLAGS,
  input  wire logic [3:0]    ALARM_LO,
  input  wire logic [3:0]    ALARM_HI,
  // Controls toward the instrument
  output logic      [1:0]    IF_MODE,
  output logic               NET_DYN,
  output logic               NET_AUTO,
  output logic               OP_SUMMARY,
  output logic      [11:0]   OUT_MODE,
  output logic      [11:0]   OUT_INPUT,
  output logic      [3:0]    OUT_PUP_EN,
  output logic      [3:0]    OUT_ON,
  output logic      [63:0]   MOUT_EFF,
  output logic      [127:0]  WORK_SP,
  output logic      [3:0]    SP_ACTIVE,
  output logic      [3:0]    RAMPING,
  output logic      [1:0]    RELAY_ON,
  output logic               CURVE_GO,
  output logic      [7:0]    CURVE_STD,
  output logic      [7:0]    CURVE_DEST
);
  localparam int SW = 44;

  // Pin synchronisers; only the second stage is read
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {LINK_STATE, NET_UNCONF, OP_COND, RDG_FLAGS, ALARM_LO, ALARM_HI, 3'h0};
      sync2_r <= sync1_r;
    end
  end
  logic [3:0]  link_s;
  logic        unconf_s;
  logic [7:0]  cond_s;
  logic [19:0] rdg_s;
  logic [3:0]  alo_s;
  logic [3:0]  ahi_s;
  assign link_s   = sync2_r[43:40];
  assign unconf_s = sync2_r[39];
  assign cond_s   = sync2_r[38:31];
  assign rdg_s    = sync2_r[30:11];
  assign alo_s    = sync2_r[10:7];
  assign ahi_s    = sync2_r[6:3];

  // Stored settings
  logic [1:0]  ifmode_r;
  logic [1:0]  netcfg_r;
  logic [31:0] netaddr_r [5];
  logic [31:0] strlen_r;
  logic [7:0]  opmask_r;
  logic [7:0]  opevent_r;
  logic        summary_r;
  logic [5:0]  relay_r [2];
  logic [1:0]  relay_on_r;
  logic [19:0] curve_r;
  logic [31:0] crvpt_r [6];
  logic        curve_go_r;
  logic [2:0]  mode_r [4];
  logic [2:0]  inp_r [4];
  logic        pup_r [4];
  logic [1:0]  rng_r [4];
  logic [15:0] mout_r [4];
  logic [31:0] setpoint_cmd_r [4];
  logic [15:0] pg_r [4];
  logic [15:0] ig_r [4];
  logic [15:0] dg_r [4];
  logic        ramp_en_r [4];
  logic [9:0]  rate_r [4];
  logic [31:0] work_r [4];
  logic [3:0]  moving;

  // Bus decode
  logic        acc;
  logic        in_out;
  logic [1:0]  oi;
  logic [2:0]  sub;
  logic        mapped;
  logic        ro;
  logic        bad;
  logic        wr;
  logic        rd_event;
  logic [31:0] rdata;
  assign acc    = PSEL & PENABLE;
  assign in_out = PADDR[11:7] == 5'h01;
  assign oi     = PADDR[6:5];
  assign sub    = PADDR[4:2];

  always_comb begin
    mapped = 1'b1;
    ro     = 1'b0;
    bad    = 1'b0;
    rdata  = '0;
    if (PADDR[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (in_out) begin
      case (sub)
        `IRC_S_MODE: begin
          rdata = {15'h0, moving[oi], 2'h0, rng_r[oi], 3'h0, pup_r[oi],
                   1'b0, inp_r[oi], 1'b0, mode_r[oi]};   // [R23]
          if (PWDATA[2:0] > 3'h5 || PWDATA[6:4] > `IRC_INPUT_MAX) bad = 1'b1;  // [R8] [R9]
          if (oi[1] && (PWDATA[2:0] == 3'h1 || PWDATA[2:0] == 3'h2)) bad = 1'b1;  // [R11]
          if (!oi[1] && (PWDATA[2:0] == 3'h4 || PWDATA[2:0] == 3'h5)) bad = 1'b1;  // [R11]
          if (oi[1] && PWDATA[13]) bad = 1'b1;  // [R16]
        end
        `IRC_S_MOUT: begin
          rdata = {16'h0, mout_r[oi]};
          if (PWDATA[15:0] > `IRC_MOUT_MAX) bad = 1'b1;
        end
        `IRC_S_SETPOINT_CMD:  rdata = setpoint_cmd_r[oi];
        `IRC_S_PGAIN: rdata = {16'h0, pg_r[oi]};
        `IRC_S_IGAIN: rdata = {16'h0, ig_r[oi]};
        `IRC_S_DGAIN: rdata = {16'h0, dg_r[oi]};
        `IRC_S_RAMP: begin
          rdata = {6'h0, rate_r[oi], 15'h0, ramp_en_r[oi]};
          if (oi[1] || PWDATA[25:16] > `IRC_RATE_MAX) bad = 1'b1;  // [R13]
        end
        default: begin
          rdata = work_r[oi];
          ro    = 1'b1;
        end
      endcase
    end else begin
      case (PADDR)
        `IRC_A_IFMODE: begin
          rdata = {30'h0, ifmode_r};  // [R1]
          if (PWDATA > 32'(`IRC_IFMODE_MAX)) bad = 1'b1;  // [R1]
        end
        `IRC_A_NETCFG:  rdata = {30'h0, netcfg_r};
        `IRC_A_NETIP:   rdata = netaddr_r[0];
        `IRC_A_NETMASK: rdata = netaddr_r[1];
        `IRC_A_NETGW:   rdata = netaddr_r[2];
        `IRC_A_NETDNS1: rdata = netaddr_r[3];
        `IRC_A_NETDNS2: rdata = netaddr_r[4];
        `IRC_A_NETSTRLEN: begin
          rdata = strlen_r;
          if (PWDATA[3:0] > `IRC_HOST_MAX || PWDATA[14:8] > `IRC_DOMAIN_MAX
              || PWDATA[21:16] > `IRC_DESC_MAX) bad = 1'b1;  // [R3]
        end
        `IRC_A_NETSTAT: begin
          rdata = {28'h0, link_s};  // [R4]
          ro    = 1'b1;
        end
        `IRC_A_OPCOND: begin
          rdata = {24'h0, cond_s};  // [R6]
          ro    = 1'b1;
        end
        `IRC_A_OPMASK: rdata = {24'h0, opmask_r};  // [R6]
        `IRC_A_OPEVENT: begin
          rdata = {24'h0, opevent_r};  // [R7]
          ro    = 1'b1;
        end
        `IRC_A_RELAY1, `IRC_A_RELAY2: begin
          rdata = {26'h0, relay_r[PADDR[2]]};
          if (PWDATA[1:0] == 2'h3 || PWDATA[5:4] == 2'h3) bad = 1'b1;
        end
        `IRC_A_RELAY_STATE_QUERY: begin
          rdata = {30'h0, relay_on_r};  // [R20]
          ro    = 1'b1;
        end
        `IRC_A_CURVE: begin
          rdata = {12'h0, curve_r};
          if (!(PWDATA[7:0] == 8'h01 || PWDATA[7:0] == 8'h06 || PWDATA[7:0] == 8'h07)
              || PWDATA[15:8] < `IRC_DEST_MIN || PWDATA[15:8] > `IRC_DEST_MAX
              || PWDATA[19:16] > `IRC_SN_MAX) bad = 1'b1;  // [R22]
        end
        default: begin
          ro = 1'b1;
          if (PADDR >= `IRC_A_NSTIP && PADDR <= `IRC_A_NSTDNS2) begin
            rdata = unconf_s ? '0 : netaddr_r[3'(PADDR[4:2] - 3'h1)];  // [R5]
          end else if (PADDR >= `IRC_A_RDGFLAG && PADDR < `IRC_A_RELAY1) begin
            rdata = {24'h0, rdg_s[5*PADDR[3:2]+4], rdg_s[5*PADDR[3:2]+3],
                     rdg_s[5*PADDR[3:2]+2], rdg_s[5*PADDR[3:2]+1],
                     3'h0, rdg_s[5*PADDR[3:2]]};  // [R18]
          end else if (PADDR >= `IRC_A_CRVPT1 && PADDR <= `IRC_A_CRVPT6) begin
            rdata = crvpt_r[3'(PADDR[4:2] - 3'h1)];
            ro    = 1'b0;
          end else begin
            mapped = 1'b0;
          end
        end
      endcase
    end
  end

  // Reads take one wait state so that PRDATA comes straight from a flip-flop
  logic        rd_hold_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) rd_hold_r <= 1'b0;
    else rd_hold_r <= acc & !PWRITE & !rd_hold_r;
  end

  assign PREADY   = PWRITE | rd_hold_r;
  assign PSLVERR  = acc & (!mapped | (PWRITE & (ro | bad)));
  assign wr       = acc & PWRITE & mapped & !ro & !bad;
  assign rd_event = acc & !PWRITE & !rd_hold_r & (PADDR == `IRC_A_OPEVENT);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) PRDATA <= `IRC_RST_WORD;
    else if (acc && !PWRITE && !rd_hold_r) PRDATA <= mapped ? rdata : '0;
  end

  // Global settings
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ifmode_r <= 2'h0;
      netcfg_r <= 2'h0;
      strlen_r <= `IRC_RST_WORD;
      opmask_r <= `IRC_RST_MASK;
      for (int k = 0; k < 5; k++) netaddr_r[k] <= `IRC_RST_WORD;
    end else if (wr && !in_out) begin
      case (PADDR)
        `IRC_A_IFMODE:    ifmode_r <= PWDATA[1:0];  // [R1]
        `IRC_A_NETCFG:    netcfg_r <= PWDATA[1:0];  // [R3]
        `IRC_A_NETIP:     netaddr_r[0] <= PWDATA;
        `IRC_A_NETMASK:   netaddr_r[1] <= PWDATA;
        `IRC_A_NETGW:     netaddr_r[2] <= PWDATA;
        `IRC_A_NETDNS1:   netaddr_r[3] <= PWDATA;
        `IRC_A_NETDNS2:   netaddr_r[4] <= PWDATA;
        `IRC_A_NETSTRLEN: strlen_r <= PWDATA & 32'h003F_7F0F;
        `IRC_A_OPMASK:    opmask_r <= PWDATA[7:0];  // [R6]
        default: ;
      endcase
    end
  end

  // Event latch: a condition seen in the read cycle survives the clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      opevent_r <= 8'h00;
      summary_r <= 1'b0;
    end else begin
      opevent_r <= (rd_event ? 8'h00 : opevent_r) | cond_s;  // [R7]
      summary_r <= |(opevent_r & opmask_r);  // [R6]
    end
  end

  // Relays
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      relay_r[0] <= 6'h00;
      relay_r[1] <= 6'h00;
      relay_on_r <= 2'h0;
    end else begin
      if (wr && !in_out && (PADDR == `IRC_A_RELAY1 || PADDR == `IRC_A_RELAY2))
        relay_r[PADDR[2]] <= PWDATA[5:0];
      for (int k = 0; k < 2; k++) begin
        case (irc_relay_mode_type'(relay_r[k][1:0]))
          IRC_RL_ON:    relay_on_r[k] <= 1'b1;
          IRC_RL_ALARM: relay_on_r[k] <=
            (relay_r[k][5:4] != 2'(IRC_AL_HIGH) && alo_s[relay_r[k][3:2]]) ||
            (relay_r[k][5:4] != 2'(IRC_AL_LOW) && ahi_s[relay_r[k][3:2]]);  // [R19]
          default:      relay_on_r[k] <= 1'b0;
        endcase
      end
    end
  end

  // Curve generation request; the go pulse fires on an accepted command write
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      curve_r    <= 20'h0;
      curve_go_r <= 1'b0;
      for (int k = 0; k < 6; k++) crvpt_r[k] <= `IRC_RST_WORD;
    end else begin
      curve_go_r <= wr && !in_out && PADDR == `IRC_A_CURVE;  // [R22]
      if (wr && !in_out && PADDR == `IRC_A_CURVE) curve_r <= PWDATA[19:0];
      if (wr && !in_out && PADDR >= `IRC_A_CRVPT1 && PADDR <= `IRC_A_CRVPT6)
        crvpt_r[3'(PADDR[4:2] - 3'h1)] <= PWDATA;
    end
  end

  // Ramp tick shared by both heater loops
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= tick_cnt_r == RAMP_TICK_CYC - 1;
      tick_cnt_r <= (tick_cnt_r == RAMP_TICK_CYC - 1) ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  // Per-output settings and loop outputs
  for (genvar g = 0; g < 4; g++) begin : g_out
    logic        sel;
    logic        ramp_live;
    logic [31:0] diff;
    logic [31:0] step;
    logic        on_r;
    logic [15:0] meff_r;
    logic        spact_r;
    assign sel       = wr && in_out && oi == 2'(g);
    assign ramp_live = (g < 2) && ramp_en_r[g] && rate_r[g] != 10'h0;  // [R13]
    assign step      = {22'h0, rate_r[g]};
    assign diff      = $signed(setpoint_cmd_r[g]) > $signed(work_r[g]) ?
                       setpoint_cmd_r[g] - work_r[g] : work_r[g] - setpoint_cmd_r[g];
    assign moving[g] = (g < 2) && work_r[g] != setpoint_cmd_r[g];  // [R15]

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        mode_r[g]    <= 3'h0;
        inp_r[g]     <= 3'h0;
        pup_r[g]     <= 1'b0;
        rng_r[g]     <= 2'h0;
        mout_r[g]    <= 16'h0;
        setpoint_cmd_r[g]    <= `IRC_RST_WORD;
        pg_r[g]      <= 16'h0;
        ig_r[g]      <= 16'h0;
        dg_r[g]      <= 16'h0;
        ramp_en_r[g] <= 1'b0;
        rate_r[g]    <= 10'h0;
      end else if (sel) begin
        case (sub)
          `IRC_S_MODE: begin
            mode_r[g] <= PWDATA[2:0];  // [R8]
            inp_r[g]  <= PWDATA[6:4];  // [R9]
            pup_r[g]  <= PWDATA[8];  // [R10]
            rng_r[g]  <= PWDATA[13:12];  // [R16]
          end
          `IRC_S_MOUT:  mout_r[g] <= PWDATA[15:0];  // [R2]
          `IRC_S_SETPOINT_CMD:  setpoint_cmd_r[g] <= PWDATA;  // [R21]
          `IRC_S_PGAIN: pg_r[g] <= PWDATA[15:0];  // [R12]
          `IRC_S_IGAIN: ig_r[g] <= PWDATA[15:0];  // [R12]
          `IRC_S_DGAIN: dg_r[g] <= PWDATA[15:0];  // [R12]
          `IRC_S_RAMP: begin
            ramp_en_r[g] <= PWDATA[0];  // [R13]
            rate_r[g]    <= PWDATA[25:16];
          end
          default: ;
        endcase
      end
    end

    // Working setpoint steps once per tick, clamped so it never overshoots
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        work_r[g] <= `IRC_RST_WORD;
      end else if (!ramp_live) begin
        work_r[g] <= setpoint_cmd_r[g];  // [R13]
      end else if (tick_r && work_r[g] != setpoint_cmd_r[g]) begin
        if (diff <= step) work_r[g] <= setpoint_cmd_r[g];  // [R14]
        else if ($signed(setpoint_cmd_r[g]) > $signed(work_r[g])) work_r[g] <= work_r[g] + step;
        else work_r[g] <= work_r[g] - step;  // [R14]
      end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        on_r    <= 1'b0;
        meff_r  <= 16'h0;
        spact_r <= 1'b0;
      end else begin
        on_r <= mode_r[g] == 3'(IRC_OM_MONITOR) ||
                (mode_r[g] != 3'(IRC_OM_OFF) && rng_r[g] != 2'h0);  // [R17]
        meff_r <= (mode_r[g] == 3'(IRC_OM_PID) || mode_r[g] == 3'(IRC_OM_ZONE) ||
                   mode_r[g] == 3'(IRC_OM_OPEN)) ? mout_r[g] : 16'h0;  // [R2]
        spact_r <= (g < 2) ? mode_r[g] != 3'(IRC_OM_OFF)
                           : mode_r[g] == 3'(IRC_OM_WARMUP);  // [R21]
      end
    end

    assign OUT_MODE[3*g +: 3]  = mode_r[g];
    assign OUT_INPUT[3*g +: 3] = inp_r[g];
    assign OUT_PUP_EN[g]       = pup_r[g];
    assign OUT_ON[g]           = on_r;
    assign MOUT_EFF[16*g +: 16] = meff_r;
    assign WORK_SP[32*g +: 32] = work_r[g];
    assign SP_ACTIVE[g]        = spact_r;
    assign RAMPING[g]          = moving[g];
  end

  assign IF_MODE    = ifmode_r;
  assign NET_DYN    = netcfg_r[0];
  assign NET_AUTO   = netcfg_r[1];
  assign OP_SUMMARY = summary_r;
  assign RELAY_ON   = relay_on_r;
  assign CURVE_GO   = curve_go_r;
  assign CURVE_STD  = curve_r[7:0];
  assign CURVE_DEST = curve_r[15:8];
endmodule

// ===== testbench/irc_chk.sv
`timescale 1ns/100ps
`include "irc_consts.svh"
module irc_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // Bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  // Results
  input wire logic [1:0]  IF_MODE,
  input wire logic        OP_SUMMARY,
  input wire logic [11:0] OUT_MODE,
  input wire logic [3:0]  OUT_ON,
  input wire logic [3:0]  SP_ACTIVE,
  input wire logic [63:0] MOUT_EFF,
  input wire logic [3:0]  RAMPING,
  input wire logic        CURVE_GO
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic       wa;
  logic [7:0] mask_r;
  assign wa = PSEL && PENABLE && PWRITE;
  // Shadow of the accepted mask, as the event register is not visible here
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      mask_r <= 8'h00;
    else if (wa && PADDR == `IRC_A_OPMASK && !PSLVERR)
      mask_r <= PWDATA[7:0];
  end
  a_err_phase: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error flag outside access phase");
  a_ifmode_take: assert property (wa && PADDR == 12'h000 && PWDATA <= 32'h2
    |=> IF_MODE == $past(PWDATA)) else $error("interface mode not stored");
  a_ifmode_keep: assert property (wa && PADDR == 12'h000 && PWDATA > 32'h2
    |-> PSLVERR ##1 $stable(IF_MODE)) else $error("bad interface mode taken");
  a_mode_place: assert property (OUT_MODE[2:0] <= 3'h3 && OUT_MODE[5:3] <= 3'h3
    && OUT_MODE[8:6] inside {3'h0, 3'h3, 3'h4, 3'h5}
    && OUT_MODE[11:9] inside {3'h0, 3'h3, 3'h4, 3'h5}) else $error("mode on wrong output");
  a_monitor_on: assert property (OUT_MODE[8:6] == 3'h4 && $stable(OUT_MODE) |-> OUT_ON[2])
    else $error("monitor output not on");
  a_off_dark: assert property (OUT_MODE[2:0] == 3'h0 && $stable(OUT_MODE)
    |-> !OUT_ON[0] && MOUT_EFF[15:0] == 16'h0) else $error("off output active");
  a_sp_warm: assert property (OUT_MODE[8:6] != 3'h5 && $stable(OUT_MODE)
    |-> !SP_ACTIVE[2]) else $error("setpoint active outside warmup");
  a_ramp_heat: assert property (RAMPING[3:2] == 2'h0)
    else $error("ramping on monitor output");
  a_sum_mask: assert property (OP_SUMMARY |-> (mask_r | $past(mask_r)) != 8'h0)
    else $error("summary with empty mask");
  a_curve_go: assert property (wa && PADDR == `IRC_A_CURVE && !PSLVERR
    |=> CURVE_GO ##1 !CURVE_GO) else $error("curve pulse wrong");
  c_curve: cover property (CURVE_GO);
  c_summary: cover property ($rose(OP_SUMMARY));
  c_ramp: cover property ($fell(RAMPING[0]));
endmodule

bind irc_unit irc_chk irc_chk_i (.*);

// ===== testbench/irc_host.sv
`timescale 1ns/100ps
module irc_host (
  // Clock
  input wire logic        clk,
  // Slave answer
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Request
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic     [11:0] paddr,
  output logic     [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Sends only what the bench asks; illegal codes only on purpose
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a stuck wait
    do @(posedge clk); while (!pready);
    er = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show junk, not the last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== testbench/irc_unit_tb.sv
`timescale 1ns/100ps
module irc_unit_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic        e;
    logic [31:0] rb;
  } irc_row_type;
  logic         CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, NET_UNCONF;
  logic         NET_DYN, NET_AUTO, OP_SUMMARY, CURVE_GO, e;
  logic [11:0]  PADDR, OUT_MODE, OUT_INPUT;
  logic [31:0]  PWDATA, PRDATA, q;
  logic [3:0]   LINK_STATE, ALARM_LO, ALARM_HI, OUT_PUP_EN, OUT_ON, SP_ACTIVE, RAMPING;
  logic [7:0]   OP_COND, CURVE_STD, CURVE_DEST;
  logic [19:0]  RDG_FLAGS;
  logic [1:0]   IF_MODE, RELAY_ON;
  logic [63:0]  MOUT_EFF;
  logic [127:0] WORK_SP;
  int           miscompares, checks, i;
  irc_row_type  rows [32] = '{
    '{12'h000, 32'h0, 1'b0, 32'h0}, '{12'h000, 32'h1, 1'b0, 32'h1},
    '{12'h000, 32'h2, 1'b0, 32'h2}, '{12'h000, 32'h3, 1'b1, 32'h2},
    '{12'h004, 32'h3, 1'b0, 32'h3}, '{12'h01C, 32'h0020_400F, 1'b0, 32'h0020_400F},
    '{12'h01C, 32'h0020_410F, 1'b1, 32'h0020_400F}, '{12'h080, 32'h3111, 1'b0, 32'h3111},
    '{12'h080, 32'h3114, 1'b1, 32'h3111}, '{12'h0A0, 32'h0052, 1'b1, 32'h0},
    '{12'h0A0, 32'h0012, 1'b0, 32'h0012}, '{12'h0A0, 32'h0006, 1'b1, 32'h0012},
    '{12'h0A0, 32'h0003, 1'b0, 32'h0003}, '{12'h0C0, 32'h0024, 1'b0, 32'h0024},
    '{12'h0C0, 32'h0021, 1'b1, 32'h0024}, '{12'h0C0, 32'h2024, 1'b1, 32'h0024},
    '{12'h0E0, 32'h1125, 1'b0, 32'h1125}, '{12'h084, 32'h2710, 1'b0, 32'h2710},
    '{12'h084, 32'h2711, 1'b1, 32'h2710}, '{12'h070, 32'h0006, 1'b0, 32'h0006},
    '{12'h074, 32'h0031, 1'b1, 32'h0}, '{12'h074, 32'h0001, 1'b0, 32'h0001},
    '{12'h100, 32'h000A_1506, 1'b0, 32'h000A_1506}, '{12'h100, 32'h2001, 1'b0, 32'h2001},
    '{12'h100, 32'h3B07, 1'b0, 32'h3B07}, '{12'h100, 32'h1502, 1'b1, 32'h3B07},
    '{12'h100, 32'h3C01, 1'b1, 32'h3B07}, '{12'h100, 32'h000B_1501, 1'b1, 32'h3B07},
    '{12'h044, 32'h5, 1'b0, 32'h5}, '{12'h040, 32'h0, 1'b1, 32'h0},
    '{12'h200, 32'h0, 1'b1, 32'h0}, '{12'h002, 32'h0, 1'b1, 32'h0}};

  irc_unit #(.RAMP_TICK_CYC(20)) irc_unit_i (.*);
  irc_host irc_host_i (.clk(CLK), .pready(PREADY), .pslverr(PSLVERR), .prdata(PRDATA),
    .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    irc_host_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    irc_host_i.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic close_out;
    $display("Compares %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  initial begin
    RESET_N = 1'b0;
    NET_UNCONF = 1'b0;
    LINK_STATE = 4'h0;
    OP_COND = 8'h00;
    RDG_FLAGS = 20'h00000;
    ALARM_LO = 4'h0;
    ALARM_HI = 4'h0;
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    chk("if_rst", 32'h0, IF_MODE);
    rd(12'h080);
    chk("out1_rst", 32'h0, q);
    foreach (rows[j]) begin
      wr(rows[j].a, rows[j].d);
      chk("refusal", rows[j].e, e);
      rd(rows[j].a);
      chk("readback", rows[j].rb, q);
    end
    chk("if_pin", 32'h2, IF_MODE);
    chk("net_flags", 32'h3, {NET_AUTO, NET_DYN});
    chk("modes", 32'hB19, OUT_MODE);
    chk("inputs", 32'h481, OUT_INPUT);
    chk("pup", 32'h9, OUT_PUP_EN);
    chk("out_on", 32'hD, OUT_ON);
    chk("sp_act", 32'hB, SP_ACTIVE);
    chk("mout1", 32'h2710, MOUT_EFF[15:0]);
    chk("curve", 32'h3B07, {CURVE_DEST, CURVE_STD});
    for (i = 0; i < 10; i++) begin
      @(posedge CLK) LINK_STATE <= i[3:0];
      rd(12'h020);
      chk("link", i, q);
    end
    wr(12'h008, 32'hC0A8_0001);
    wr(12'h018, 32'h0A00_0002);
    @(posedge CLK) NET_UNCONF <= 1'b1;
    rd(12'h024);
    chk("ip_unconf", 32'h0, q);
    rd(12'h034);
    chk("dns_unconf", 32'h0, q);
    @(posedge CLK) NET_UNCONF <= 1'b0;
    rd(12'h024);
    chk("ip_view", 32'hC0A8_0001, q);
    rd(12'h034);
    chk("dns_view", 32'h0A00_0002, q);
    @(posedge CLK) OP_COND <= 8'h02;
    @(posedge CLK) OP_COND <= 8'h00;
    repeat (5) @(posedge CLK);
    chk("sum_masked", 32'h0, OP_SUMMARY);
    @(posedge CLK) OP_COND <= 8'h04;
    @(posedge CLK) OP_COND <= 8'h00;
    repeat (5) @(posedge CLK);
    chk("sum_set", 32'h1, OP_SUMMARY);
    rd(12'h048);
    chk("event", 32'h6, q);
    rd(12'h048);
    chk("event_clr", 32'h0, q);
    chk("sum_clr", 32'h0, OP_SUMMARY);
    @(posedge CLK) OP_COND <= 8'h81;
    rd(12'h040);
    chk("cond", 32'h81, q);
    @(posedge CLK) RDG_FLAGS <= 20'h0440E;
    rd(12'h060);
    chk("rdg_a", 32'h70, q);
    rd(12'h068);
    chk("rdg_c", 32'h81, q);
    @(posedge CLK) ALARM_LO <= 4'h2;
    @(posedge CLK);
    rd(12'h078);
    chk("relay_lo", 32'h3, q);
    chk("relay_pin", 32'h3, RELAY_ON);
    @(posedge CLK) ALARM_LO <= 4'h0;
    ALARM_HI <= 4'h2;
    @(posedge CLK);
    rd(12'h078);
    chk("relay_hi", 32'h2, q);
    wr(12'h070, 32'h0026);
    rd(12'h078);
    chk("relay_both", 32'h3, q);
    for (i = 0; i < 3; i++) begin
      wr(12'h08C + 12'(4 * i), i + 7);
      rd(12'h08C + 12'(4 * i));
      chk("gain", i + 7, q);
    end
    wr(12'h098, 32'h03E8_0001);
    wr(12'h088, 32'h1388);
    rd(12'h080);
    chk("ramp_st", 32'h1, q[16]);
    repeat (200) @(posedge CLK);
    chk("ramp_up", 32'h1388, WORK_SP[31:0]);
    chk("ramp_done", 32'h0, RAMPING[0]);
    wr(12'h088, 32'hFFFF_F830);
    repeat (2) @(posedge CLK);
    chk("ramp_dn_st", 32'h1, RAMPING[0]);
    repeat (200) @(posedge CLK);
    rd(12'h09C);
    chk("ramp_dn", 32'hFFFF_F830, q);
    wr(12'h098, 32'h0000_0001);
    wr(12'h088, 32'h64);
    repeat (2) @(posedge CLK);
    chk("rate_zero", 32'h64, WORK_SP[31:0]);
    wr(12'h098, 32'h03E9_0001);
    chk("rate_max", 32'h1, e);
    wr(12'h0D8, 32'h03E8_0001);
    chk("ramp_out3", 32'h1, e);
    wr(12'h080, 32'h3110);
    repeat (3) @(posedge CLK);
    chk("off_on", 32'h0, OUT_ON[0]);
    chk("off_mout", 32'h0, MOUT_EFF[15:0]);
    chk("off_sp", 32'h0, SP_ACTIVE[0]);
    @(posedge CLK) RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(12'h000);
    chk("if_rerst", 32'h0, q);
    close_out();
  end
endmodule
